// ===== bdl_baud_loopback.sv
// Purpose: baud divisor selection, receiver clock select and echo path
// Assumes: crystal, receive clock and rxd pins are asynchronous to core_clk
// Notes:   crystal must run below a quarter of core_clk to be counted
`timescale 1ns/10ps
`default_nettype none
module bdl_baud_loopback #(
	parameter int DIV_W = bdl_pkg::DIV_W
) (
	input  wire logic                     core_clk,
	input  wire logic                     rst,
	input  wire bdl_pkg::bdl_apb_req_t    apbReq,
	output logic [bdl_pkg::DATA_W-1:0]    prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic                     crystalClockInput,
	input  wire logic                     rxClkIn,
	input  wire logic                     rxd,
	input  wire logic                     txSerialIn,
	output logic                          txd,
	output logic                          rtsN,
	output logic                          txBitTick,
	output logic                          rxBitTick,
	output logic                          txIrqEnable,
	output logic                          rxIrqEnable
);
	if (DIV_W < bdl_pkg::DIV_W) begin : g_chk
		$error("DIV_W too small for the divisor table");
	end

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] syncA_reg, syncB_reg, syncC_reg;
	logic [2:0] syncA_next, syncB_next, syncC_next;
	logic       xtalEdge, rxClkEdge, rxdSync;

	always_comb begin
		syncA_next = {rxd, rxClkIn, crystalClockInput};
		syncB_next = syncA_reg;
		syncC_next = syncB_reg;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			syncA_reg <= 3'h0;
			syncB_reg <= 3'h0;
			syncC_reg <= 3'h0;
		end else begin
			syncA_reg <= syncA_next;
			syncB_reg <= syncB_next;
			syncC_reg <= syncC_next;
		end
	end

	assign xtalEdge  = syncB_reg[0] & ~syncC_reg[0];
	assign rxClkEdge = syncB_reg[1] & ~syncC_reg[1];
	assign rxdSync   = syncB_reg[2];

	// ----------------------------------------------------------------
	// apb registers
	// ----------------------------------------------------------------
	logic [7:0]                     ctrl_reg, ctrl_next;
	logic [7:0]                     cmd_reg, cmd_next;
	logic [bdl_pkg::DATA_W-1:0]     rdata_reg, rdata_next;
	logic                           err_reg, err_next;
	logic [bdl_pkg::STAT_CNT_W-1:0] tickCnt_reg, tickCnt_next;
	logic                           setup, wrAccess, rateLoad, echoMode, rxInternal;
	logic [bdl_pkg::RATE_W-1:0]     rateCode;

	assign setup      = apbReq.psel & ~apbReq.penable;
	assign wrAccess   = apbReq.psel & apbReq.penable & apbReq.pwrite;
	assign rateLoad   = wrAccess && apbReq.paddr == bdl_pkg::CTRL_OFF;
	assign rateCode   = ctrl_reg[bdl_pkg::CTRL_RATE_LSB +: bdl_pkg::RATE_W];
	assign echoMode   = cmd_reg[bdl_pkg::CMD_ECHO];
	assign rxInternal = ctrl_reg[bdl_pkg::CTRL_RXSRC];

	always_comb begin
		ctrl_next    = ctrl_reg;
		cmd_next     = cmd_reg;
		rdata_next   = rdata_reg;
		err_next     = err_reg;
		tickCnt_next = tickCnt_reg + {{(bdl_pkg::STAT_CNT_W-1){1'b0}}, txBitTick};
		if (wrAccess && apbReq.paddr == bdl_pkg::CTRL_OFF) begin
			ctrl_next = apbReq.pwdata[7:0];
		end else if (wrAccess && apbReq.paddr == bdl_pkg::CMD_OFF) begin
			cmd_next = apbReq.pwdata[7:0];
		end
		if (setup) begin
			err_next   = 1'b0;
			rdata_next = '0;
			if (apbReq.paddr == bdl_pkg::CTRL_OFF) begin
				rdata_next[7:0] = ctrl_reg;
			end else if (apbReq.paddr == bdl_pkg::CMD_OFF) begin
				rdata_next[7:0] = cmd_reg;
			end else if (apbReq.paddr == bdl_pkg::STAT_OFF) begin
				rdata_next[bdl_pkg::STAT_ECHO]  = echoMode;
				rdata_next[bdl_pkg::STAT_RXINT] = rxInternal;
				rdata_next[bdl_pkg::STAT_CNT_LSB +: bdl_pkg::STAT_CNT_W] = tickCnt_reg;
			end else begin
				err_next = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_reg    <= bdl_pkg::CTRL_RST;
			cmd_reg     <= bdl_pkg::CMD_RST;
			rdata_reg   <= '0;
			err_reg     <= 1'b0;
			tickCnt_reg <= '0;
		end else begin
			ctrl_reg    <= ctrl_next;
			cmd_reg     <= cmd_next;
			rdata_reg   <= rdata_next;
			err_reg     <= err_next;
			tickCnt_reg <= tickCnt_next;
		end
	end

	assign pready      = 1'b1;
	assign prdata      = rdata_reg;
	assign pslverr     = apbReq.psel & apbReq.penable & err_reg;
	assign txIrqEnable = cmd_reg[bdl_pkg::CMD_TXC_LSB +: 2] != bdl_pkg::TXC_IRQ_OFF;
	assign rxIrqEnable = cmd_reg[bdl_pkg::CMD_RXIRQ];

	// ----------------------------------------------------------------
	// bit-rate dividers
	// ----------------------------------------------------------------
	logic [DIV_W-1:0] txCnt_reg, txCnt_next, rxCnt_reg, rxCnt_next, txDiv;
	logic             txBit_next, rxBit_next, txHalf, rxHalf, txEnd, rxEnd, anyHalf;

	// code zero falls back to a divide by sixteen of the crystal input
	assign txDiv = DIV_W'(bdl_pkg::rateDivisor(rateCode));
	assign txEnd = xtalEdge && txCnt_reg == txDiv - 1'b1;
	assign txHalf = xtalEdge && txCnt_reg == (txDiv >> 1) - 1'b1;
	assign rxEnd = rxClkEdge && rxCnt_reg == DIV_W'(bdl_pkg::EXT_DIV) - 1'b1;
	assign rxHalf = rxClkEdge && rxCnt_reg == DIV_W'(bdl_pkg::EXT_DIV >> 1) - 1'b1;

	always_comb begin
		txCnt_next = txCnt_reg;
		rxCnt_next = rxCnt_reg;
		if (rateLoad) begin
			txCnt_next = '0;
			rxCnt_next = '0;
		end else begin
			if (xtalEdge) begin
				txCnt_next = txEnd ? '0 : txCnt_reg + 1'b1;
			end
			if (rxClkEdge) begin
				rxCnt_next = rxEnd ? '0 : rxCnt_reg + 1'b1;
			end
		end
		txBit_next = txEnd && !rateLoad;
		// receiver clock taken from the transmitter rate when selected
		rxBit_next = rxInternal ? txBit_next : (rxEnd && !rateLoad);
		anyHalf    = rxInternal ? (txHalf || txEnd) : (rxHalf || rxEnd);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			txCnt_reg <= '0;
			rxCnt_reg <= '0;
			txBitTick <= 1'b0;
			rxBitTick <= 1'b0;
		end else begin
			txCnt_reg <= txCnt_next;
			rxCnt_reg <= rxCnt_next;
			txBitTick <= txBit_next;
			rxBitTick <= rxBit_next;
		end
	end

	// ----------------------------------------------------------------
	// echo path and modem outputs
	// ----------------------------------------------------------------
	logic echoSample_reg, echoSample_next, txd_next, rtsN_next;

	always_comb begin
		echoSample_next = echoSample_reg;
		// sampled at each half-bit point, so tx lags rx by half a bit
		if (anyHalf) begin
			echoSample_next = rxdSync;
		end
		// only the echo or the local transmitter feeds tx, never a loop
		txd_next  = echoMode ? echoSample_reg : txSerialIn;
		rtsN_next = echoMode ? 1'b0
			: (cmd_reg[bdl_pkg::CMD_TXC_LSB +: 2] == bdl_pkg::TXC_RTS_OFF);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			echoSample_reg <= 1'b1;
			txd            <= 1'b1;
			rtsN           <= 1'b1;
		end else begin
			echoSample_reg <= echoSample_next;
			txd            <= txd_next;
			rtsN           <= rtsN_next;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_cmdWrite;
		wrAccess && apbReq.paddr == bdl_pkg::CMD_OFF;
	endsequence

	sequence s_halfPoint;
		echoMode && anyHalf;
	endsequence

	sequence s_ctrlWrite;
		wrAccess && apbReq.paddr == bdl_pkg::CTRL_OFF;
	endsequence

	a_ext_rate_tick: assert property (@(posedge core_clk) disable iff (rst)
		(rateCode == 4'h0 && xtalEdge && txCnt_reg == 16'h000f && !rateLoad) |=> txBitTick)
		else $error("code zero did not tick after sixteen crystal edges");

	a_divisor_tick: assert property (@(posedge core_clk) disable iff (rst)
		(rateCode == 4'hf && xtalEdge && txCnt_reg == 16'h005f && !rateLoad) |=> txBitTick)
		else $error("fastest rate did not tick at divisor 96");

	a_count_bound: assert property (@(posedge core_clk) disable iff (rst)
		txCnt_reg < DIV_W'(bdl_pkg::rateDivisor(rateCode)))
		else $error("divider count passed the selected divisor");

	a_rate_restart: assert property (@(posedge core_clk) disable iff (rst)
		rateLoad |=> (txCnt_reg == '0 && !txBitTick))
		else $error("divider did not restart on rate rewrite");

	a_rx_clk_share: assert property (@(posedge core_clk) disable iff (rst)
		$past(rxInternal) |-> rxBitTick == txBitTick)
		else $error("receiver tick differs from transmitter tick");

	a_echo_delay: assert property (@(posedge core_clk) disable iff (rst)
		s_halfPoint ##1 (echoMode && !anyHalf) |=> txd == $past(rxdSync, 2))
		else $error("echo output not the half-bit sample of rx");

	a_echo_source: assert property (@(posedge core_clk) disable iff (rst)
		($past(echoMode) && $past(txSerialIn) != $past(echoSample_reg)) |-> txd != $past(txSerialIn))
		else $error("local transmitter reached tx in echo mode");

	a_echo_rts: assert property (@(posedge core_clk) disable iff (rst)
		(s_cmdWrite and apbReq.pwdata[bdl_pkg::CMD_ECHO]) |=> ##1 !rtsN)
		else $error("rts not low after selecting echo");

	a_echo_select: assert property (@(posedge core_clk) disable iff (rst)
		(s_cmdWrite and apbReq.pwdata[bdl_pkg::CMD_ECHO]) |=> echoMode)
		else $error("echo mode not entered");

	a_tx_irq_off: assert property (@(posedge core_clk) disable iff (rst)
		(s_cmdWrite and apbReq.pwdata[3:2] == 2'h2) |=> !txIrqEnable)
		else $error("tx interrupt enable not cleared");

	a_rx_irq_off: assert property (@(posedge core_clk) disable iff (rst)
		(s_cmdWrite and !apbReq.pwdata[bdl_pkg::CMD_RXIRQ]) |=> !rxIrqEnable)
		else $error("rx interrupt enable not cleared");

	a_tick_single: assert property (@(posedge core_clk) disable iff (rst)
		txBitTick |=> !txBitTick)
		else $error("transmitter tick lasted more than one cycle");

	a_tick_quiet: assert property (@(posedge core_clk) disable iff (rst)
		!txEnd |=> !txBitTick)
		else $error("transmitter tick without terminal count");

	a_rx_ext_tick: assert property (@(posedge core_clk) disable iff (rst)
		(!rxInternal && rxEnd && !rateLoad) |=> rxBitTick)
		else $error("external receive clock did not tick");

	a_rx_ext_quiet: assert property (@(posedge core_clk) disable iff (rst)
		(!rxInternal && !rxEnd) |=> !rxBitTick)
		else $error("receiver tick without external count end");

	a_rx_src_select: assert property (@(posedge core_clk) disable iff (rst)
		(s_ctrlWrite and apbReq.pwdata[bdl_pkg::CTRL_RXSRC]) |=> rxInternal)
		else $error("receiver clock source not switched to transmitter");

	a_rate_zero_load: assert property (@(posedge core_clk) disable iff (rst)
		(s_ctrlWrite and apbReq.pwdata[3:0] == 4'h0) |=> rateCode == 4'h0)
		else $error("rate code zero not loaded");

	a_local_tx_path: assert property (@(posedge core_clk) disable iff (rst)
		!echoMode |=> txd == $past(txSerialIn))
		else $error("tx not fed by the local transmitter outside echo");

	a_echo_hold: assert property (@(posedge core_clk) disable iff (rst)
		(echoMode && !anyHalf) |=> $stable(echoSample_reg))
		else $error("echo sample changed between half-bit points");

	a_rts_idle: assert property (@(posedge core_clk) disable iff (rst)
		(!echoMode && cmd_reg[bdl_pkg::CMD_TXC_LSB +: 2] == bdl_pkg::TXC_RTS_OFF) |=> rtsN)
		else $error("rts active without echo or command request");

	a_tx_irq_on: assert property (@(posedge core_clk) disable iff (rst)
		(s_cmdWrite and apbReq.pwdata[3:2] != bdl_pkg::TXC_IRQ_OFF) |=> txIrqEnable)
		else $error("tx interrupt enable not set");

	a_rx_irq_on: assert property (@(posedge core_clk) disable iff (rst)
		(s_cmdWrite and apbReq.pwdata[bdl_pkg::CMD_RXIRQ]) |=> rxIrqEnable)
		else $error("rx interrupt enable not set");

	a_echo_leave: assert property (@(posedge core_clk) disable iff (rst)
		(s_cmdWrite and !apbReq.pwdata[bdl_pkg::CMD_ECHO]) |=> !echoMode)
		else $error("echo mode not left");
endmodule
`default_nettype wire

// ===== bdl_pkg.sv
// Purpose: constants, register map and types of the baud divider and echo block
// Assumes: APB slave, 32-bit data, one core clock of 20 MHz
// Notes:   rate codes pick a crystal divisor; echo mode turns rx back out on tx
//
// Behaviour
// - code zero: bit rate is crystal/16
// - codes 1..15 select the fixed divisor table
// - no built-in loop-back switching in here
// - control bit 4: receiver uses transmitter clock
// - command bit 4 selects echo mode
// - command bits 3:2 = 10 disable tx interrupts
// - command bit 1 zero disables rx interrupts
// - echo resends received data, no processor involved
// - echo output lags receive input half bit
// - echo mode drives rts low
// - control bits 3:0 choose the divisor
package bdl_pkg;
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;
	localparam int          DIV_W         = 16;
	localparam int          RATE_W        = 4;
	localparam int          STAT_CNT_W    = 8;
	localparam logic [7:0]  CTRL_OFF      = 8'h00;
	localparam logic [7:0]  CMD_OFF       = 8'h04;
	localparam logic [7:0]  STAT_OFF      = 8'h08;
	localparam logic [7:0]  CTRL_RST      = 8'h00;
	localparam logic [7:0]  CMD_RST       = 8'h00;
	localparam int          CTRL_RATE_LSB = 0;
	localparam int          CTRL_RXSRC    = 4;
	localparam int          CMD_RXIRQ     = 1;
	localparam int          CMD_TXC_LSB   = 2;
	localparam int          CMD_ECHO      = 4;
	localparam logic [1:0]  TXC_IRQ_OFF   = 2'h2;
	localparam logic [1:0]  TXC_RTS_OFF   = 2'h0;
	localparam int          STAT_ECHO     = 0;
	localparam int          STAT_RXINT    = 1;
	localparam int          STAT_CNT_LSB  = 8;
	localparam logic [15:0] EXT_DIV       = 16'h0010;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} bdl_apb_req_t;

	// divisor per rate code, in crystal edges per bit
	function automatic logic [DIV_W-1:0] rateDivisor(input logic [RATE_W-1:0] code);
		case (code)
			4'h1: rateDivisor = 16'h9000;
			4'h2: rateDivisor = 16'h6000;
			4'h3: rateDivisor = 16'h4180;
			4'h4: rateDivisor = 16'h3580;
			4'h5: rateDivisor = 16'h3000;
			4'h6: rateDivisor = 16'h1800;
			4'h7: rateDivisor = 16'h0c00;
			4'h8: rateDivisor = 16'h0600;
			4'h9: rateDivisor = 16'h0400;
			4'ha: rateDivisor = 16'h0300;
			4'hb: rateDivisor = 16'h0200;
			4'hc: rateDivisor = 16'h0180;
			4'hd: rateDivisor = 16'h0100;
			4'he: rateDivisor = 16'h00c0;
			4'hf: rateDivisor = 16'h0060;
			default: rateDivisor = EXT_DIV;
		endcase
	endfunction
endpackage

// ===== bdl_modem_model.sv
// Purpose: far-side model: crystal, receive clock, modem line and local loop gating
// Assumes: crystal period is eight core clocks, free running oscillator
// Notes:   local loop select is driven by the bench as a peripheral output
`timescale 1ns/10ps
`default_nettype none
module bdl_modem_model (
	input  wire logic localLoopbackSelect,
	input  wire logic lineRxd,
	input  wire logic txd,
	input  wire logic rtsN,
	output logic      crystalClockInput,
	output logic      rxClkIn,
	output logic      rxd,
	output logic      modemTxd,
	output logic      modemRtsN
);
	// ----------------------------------------
	// clocks
	// ----------------------------------------
	initial begin
		crystalClockInput = 1'b0;
		#7;
		forever #200 crystalClockInput = ~crystalClockInput;
	end
	initial begin
		rxClkIn = 1'b0;
		forever #150 rxClkIn = ~rxClkIn;
	end
	// ----------------------------------------
	// loop gating, select active high
	// ----------------------------------------
	assign rxd       = localLoopbackSelect ? txd : lineRxd;
	assign modemTxd  = localLoopbackSelect ? 1'b1 : txd;
	assign modemRtsN = localLoopbackSelect ? 1'b1 : rtsN;
endmodule
`default_nettype wire

// ===== bdl_baud_loopback_tb_top.sv
// Purpose: self-checking bench of the baud divider and echo block
// Assumes: zero-wait APB slave, crystal at eight core clocks per period
// Notes:   long rate codes are written and read back, short ones timed
`timescale 1ns/10ps
`default_nettype none
module bdl_baud_loopback_tb_top;
	logic                   core_clk;
	logic                   rst;
	bdl_pkg::bdl_apb_req_t  req;
	logic [31:0]            prdata;
	logic                   pready, pslverr, crystal, rxClk, rxd, txSerialIn, txd, rtsN;
	logic                   txTick, rxTick, txIrqEn, rxIrqEn, llSel, lineRxd, modemTxd;
	logic [31:0]            rd;
	logic                   er;
	int                     errCount, totalChecks;

	bdl_baud_loopback uut (.core_clk(core_clk), .rst(rst), .apbReq(req), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .crystalClockInput(crystal), .rxClkIn(rxClk),
		.rxd(rxd), .txSerialIn(txSerialIn), .txd(txd), .rtsN(rtsN), .txBitTick(txTick),
		.rxBitTick(rxTick), .txIrqEnable(txIrqEn), .rxIrqEnable(rxIrqEn));
	bdl_modem_model modem (.localLoopbackSelect(llSel), .lineRxd(lineRxd), .txd(txd),
		.rtsN(rtsN), .crystalClockInput(crystal), .rxClkIn(rxClk), .rxd(rxd),
		.modemTxd(modemTxd), .modemRtsN());

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			errCount++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge core_clk);
		req.penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		check("pready", {31'h0, pready}, 32'h1);
		rd = prdata;
		er = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic waitTick();
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (txTick !== 1'b1 && n < 5000);
		if (txTick !== 1'b1) errCount++;
	endtask
	task wrap_up();
		$display("checks %0d mismatches %0d", totalChecks, errCount);
		if (errCount == 0 && totalChecks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic regScenario();
		apb(1'b0, bdl_pkg::CTRL_OFF, 32'h0);
		check("ctrl reset", rd, 32'h0);
		apb(1'b0, 8'h3c, 32'h0);
		check("unmapped err", {31'h0, er}, 32'h1);
		for (int c = 0; c < 16; c++) begin
			apb(1'b1, bdl_pkg::CTRL_OFF, c);
			apb(1'b0, bdl_pkg::CTRL_OFF, 32'h0);
			check("rate code", rd, c);
		end
	endtask
	task automatic rateScenario(input logic [3:0] code, input int edges);
		int n;
		apb(1'b1, bdl_pkg::CTRL_OFF, {28'h0, code});
		waitTick();
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (txTick !== 1'b1 && n < 5000);
		check("tick period", n, edges * 8);
	endtask
	task automatic rxExtScenario();
		int n;
		apb(1'b1, bdl_pkg::CTRL_OFF, 32'h0);
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (rxTick !== 1'b1 && n < 5000);
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (rxTick !== 1'b1 && n < 5000);
		check("rx ext period", n, 32'h60);
	endtask
	task automatic irqScenario(input logic [7:0] cmd);
		apb(1'b1, bdl_pkg::CMD_OFF, cmd);
		repeat (2) @(posedge core_clk);
		check("tx irq", txIrqEn, cmd[3:2] != 2'b10);
		check("rx irq", rxIrqEn, cmd[1]);
		check("rts", rtsN, cmd[3:2] == 2'b00);
	endtask
	task automatic echoScenario();
		int t, r;
		apb(1'b1, bdl_pkg::CTRL_OFF, 32'h10);
		apb(1'b1, bdl_pkg::CMD_OFF, 32'h18);
		apb(1'b0, bdl_pkg::STAT_OFF, 32'h0);
		check("echo status", rd[1:0], 2'h3);
		check("echo rts", rtsN, 1'b0);
		check("echo irqs", {txIrqEn, rxIrqEn}, 2'b00);
		t = 0;
		r = 0;
		for (int i = 0; i < 512; i++) begin
			@(posedge core_clk);
			t += txTick;
			r += rxTick;
		end
		check("rx ticks", r, t);
		waitTick();
		lineRxd <= 1'b0;
		repeat (48) @(posedge core_clk);
		check("echo early", txd, 1'b1);
		repeat (48) @(posedge core_clk);
		check("echo late", txd, 1'b0);
		lineRxd <= 1'b1;
	endtask
	task automatic loopScenario();
		apb(1'b1, bdl_pkg::CMD_OFF, 32'h0);
		lineRxd <= 1'b0;
		txSerialIn <= 1'b1;
		repeat (300) @(posedge core_clk);
		check("no inner loop", txd, 1'b1);
		llSel <= 1'b1;
		txSerialIn <= 1'b0;
		repeat (8) @(posedge core_clk);
		check("local tx", txd, 1'b0);
		check("modem blocked", modemTxd, 1'b1);
		llSel <= 1'b0;
		lineRxd <= 1'b1;
	endtask
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		errCount = 0;
		totalChecks = 0;
		req = '0;
		rst = 1'b1;
		txSerialIn = 1'b1;
		llSel = 1'b0;
		lineRxd = 1'b1;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		regScenario();
		rateScenario(4'h0, 16);
		rateScenario(4'hf, 96);
		rateScenario(4'he, 192);
		rateScenario(4'hd, 256);
		rxExtScenario();
		irqScenario(8'h00);
		irqScenario(8'h02);
		irqScenario(8'h04);
		irqScenario(8'h08);
		irqScenario(8'h0c);
		echoScenario();
		loopScenario();
		wrap_up();
	end
	initial begin
		#2ms;
		errCount++;
		wrap_up();
	end
endmodule
`default_nettype wire
